// [gptu_pkg.sv]
// gptu_pkg: constants, register map and pin bundles of the timer unit.
// assumes one 50 MHz clock (pclk) and an APB register port.
`default_nettype none
package gptu_pkg;
	localparam int GPTU_NT = 5;
	localparam int GPTU_TW = 16;
	// timer indices: module one 0..2, module two 3..4
	localparam int IDX_AUX_A = 0;
	localparam int IDX_CORE1 = 1;
	localparam int IDX_AUX_B = 2;
	localparam int IDX_AUX2 = 3;
	localparam int IDX_CORE2 = 4;
	localparam int MOD2_FIRST = 3;
	// register byte offsets
	localparam logic [11:0] OFF_CTL = 12'h000;
	localparam logic [11:0] OFF_CAPCTL = 12'h018;
	localparam logic [11:0] OFF_STATUS = 12'h01C;
	localparam logic [11:0] OFF_VAL = 12'h020;
	localparam logic [11:0] OFF_CAPREG = 12'h034;
	// timer control word fields
	localparam int F_MODE = 0;
	localparam int F_PRE = 3;
	localparam int F_RUN = 6;
	localparam int F_DOWN = 7;
	localparam int F_EXTUD = 8;
	localparam int F_EDGE = 9;
	localparam int F_OUTEN = 11;
	localparam int F_LATCLK = 12;
	localparam int F_TRIG = 13;
	localparam int F_CORERLD = 15;
	// capture control fields
	localparam int C_EDGE = 0;
	localparam int C_SRC = 2;
	localparam int C_CLEAR = 4;
	localparam int CAPCTL_W = 5;
	// reset values
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] VAL_RST = 16'h0000;
	localparam logic [4:0] CAPCTL_RST = 5'h00;
	// fastest count step, in system clock cycles
	localparam int DIV1_MIN = 4;
	localparam int DIV2_MIN = 2;
	localparam int PRE_W = 10;

	typedef enum logic [2:0] {
		MODE_TIMER, MODE_COUNTER, MODE_GATE_HI, MODE_GATE_LO,
		MODE_RELOAD, MODE_CAPTURE, MODE_INCR
	} gptu_mode_t;

	typedef struct packed {
		logic [GPTU_NT-1:0] timer_input_pin;
		logic [GPTU_NT-1:0] ext_updown_pin;
		logic capture_input_pin;
	} gptu_pins_t;

	typedef struct packed {
		logic core_one_toggle_out;
		logic core_two_toggle_out;
		logic core_two_ovf;
	} gptu_outs_t;
endpackage : gptu_pkg
`default_nettype wire

// [gptu_top.sv]
// gptu_top: five 16-bit up/down timers in two modules behind APB.
// assumes pins are synchronous-ish levels, sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
module gptu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire gptu_pkg::gptu_pins_t pins,
	output var gptu_pkg::gptu_outs_t outs
);
	import gptu_pkg::*;

	logic [15:0] tval [GPTU_NT];
	logic [15:0] tctl [GPTU_NT];
	logic [15:0] ld_val [GPTU_NT];
	logic [GPTU_NT-1:0] ld_en;
	logic [GPTU_NT-1:0] ev_in;
	logic [GPTU_NT-1:0] step;
	logic [GPTU_NT-1:0] down;
	logic [GPTU_NT-1:0] ovf;
	logic [2:0] s_in [GPTU_NT];
	logic [2:0] s_ud [GPTU_NT];
	logic [2:0] s_cap;
	logic [15:0] capreg;
	logic [CAPCTL_W-1:0] capctl;
	logic [PRE_W-1:0] pre_cnt;
	logic latch1;
	logic latch1_d;
	logic latch2;
	logic latch2_d;
	logic cap_fire;
	logic wr;
	logic acc;
	logic hit;
	logic [31:0] next_rdata;

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic now, input logic was);
		return (sel[0] & now & ~was) | (sel[1] & ~now & was);
	endfunction : edge_hit

	// shared prescaler base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
		end
	end

	// two flops then an edge-detect copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < GPTU_NT; k++) begin
				s_in[k] <= 3'h0;
				s_ud[k] <= 3'h0;
			end
			s_cap <= 3'h0;
		end else begin
			for (int k = 0; k < GPTU_NT; k++) begin
				s_in[k] <= {s_in[k][1:0], pins.timer_input_pin[k]};
				s_ud[k] <= {s_ud[k][1:0], pins.ext_updown_pin[k]};
			end
			s_cap <= {s_cap[1:0], pins.capture_input_pin};
		end
	end

	for (genvar i = 0; i < GPTU_NT; i++) begin : g_tmr
		localparam bit MOD1 = (i < MOD2_FIRST);
		localparam logic [PRE_W-1:0] SLOT =
			PRE_W'((MOD1 ? DIV1_MIN : DIV2_MIN) - 1);
		gptu_mode_t mode;
		logic [PRE_W-1:0] mask;
		logic slot;
		logic tick;
		logic timed;
		logic lat;
		logic lat_d;
		logic cnt_ev;
		logic qa;
		logic qb;
		logic qdown;
		logic raw_ev;
		logic raw_dn;
		logic pend;
		logic pend_dn;
		logic hit_val;

		assign mode = gptu_mode_t'(tctl[i][F_MODE +: 3]);
		// divide base is 4 or 2 cycles
		assign mask = PRE_W'(((MOD1 ? DIV1_MIN : DIV2_MIN)
			<< tctl[i][F_PRE +: 3]) - 1);
		assign slot = (pre_cnt & SLOT) == SLOT;
		assign tick = (pre_cnt & mask) == mask;
		assign ev_in[i] = edge_hit(tctl[i][F_EDGE +: 2], s_in[i][1],
			s_in[i][2]);
		assign lat = MOD1 ? latch1 : latch2;
		assign lat_d = MOD1 ? latch1_d : latch2_d;
		assign cnt_ev = tctl[i][F_LATCLK] ?
			edge_hit(tctl[i][F_EDGE +: 2], lat, lat_d) : ev_in[i];
		// quadrature: A on timer pin, B on updown pin
		assign qa = tctl[i][F_EDGE] & (s_in[i][1] ^ s_in[i][2]);
		assign qb = tctl[i][F_EDGE+1] & (s_ud[i][1] ^ s_ud[i][2]);
		assign qdown = qa ? (s_in[i][1] == s_ud[i][1]) :
			(s_in[i][1] != s_ud[i][1]);

		always_comb begin
			timed = 1'b0;
			raw_ev = 1'b0;
			raw_dn = 1'b0;
			case (mode)
				MODE_TIMER: timed = tick;
				MODE_GATE_HI: timed = tick & s_in[i][1];
				MODE_GATE_LO: timed = tick & ~s_in[i][1];
				MODE_COUNTER: raw_ev = cnt_ev;
				MODE_INCR: begin
					raw_ev = MOD1 & (qa | qb);
					raw_dn = qdown;
				end
				default: timed = 1'b0;
			endcase
		end

		// events held until the next allowed step slot
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pend <= 1'b0;
				pend_dn <= 1'b0;
			end else begin
				pend <= slot ? 1'b0 : (pend | raw_ev);
				if (raw_ev) begin
					pend_dn <= raw_dn;
				end
			end
		end

		assign step[i] = tctl[i][F_RUN] &
			(timed | (slot & (pend | raw_ev)));
		assign down[i] = (mode == MODE_INCR) ?
			((raw_ev ? raw_dn : pend_dn) ^ tctl[i][F_DOWN]) :
			(tctl[i][F_DOWN] ^ (tctl[i][F_EXTUD] & s_ud[i][1]));
		assign ovf[i] = step[i] &
			(down[i] ? (tval[i] == 16'h0000) : (tval[i] == 16'hFFFF));
		assign hit_val = wr & (paddr == 12'(OFF_VAL + 4 * i));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tval[i] <= VAL_RST;
			end else if (hit_val) begin
				tval[i] <= pwdata[15:0];
			end else if (ld_en[i]) begin
				tval[i] <= ld_val[i];
			end else if (step[i]) begin
				tval[i] <= down[i] ? tval[i] - 1'b1 : tval[i] + 1'b1;
			end
		end
	end

	// capture trigger for the capture register
	always_comb begin
		case (capctl[C_SRC +: 2])
			2'b00: cap_fire = edge_hit(capctl[C_EDGE +: 2], s_cap[1],
				s_cap[2]);
			2'b01: cap_fire = edge_hit(capctl[C_EDGE +: 2],
				s_in[IDX_CORE1][1], s_in[IDX_CORE1][2]);
			2'b10: cap_fire = edge_hit(capctl[C_EDGE +: 2],
				s_ud[IDX_CORE1][1], s_ud[IDX_CORE1][2]);
			default: cap_fire = edge_hit(capctl[C_EDGE +: 2],
				s_in[IDX_CORE1][1], s_in[IDX_CORE1][2]) |
				edge_hit(capctl[C_EDGE +: 2], s_ud[IDX_CORE1][1],
				s_ud[IDX_CORE1][2]);
		endcase
	end

	// reload request of one aux timer towards core one
	function automatic logic reload_hit(
		input logic [15:0] ctl,
		input logic pin_ev,
		input logic wrap,
		input logic lat_now
	);
		logic fire;
		fire = 1'b0;
		if (gptu_mode_t'(ctl[F_MODE +: 3]) == MODE_RELOAD) begin
			// lat_now is the level before the wrap flips it
			case (ctl[F_TRIG +: 2])
				2'b00: fire = pin_ev;
				2'b01: fire = wrap & ~lat_now;
				2'b10: fire = wrap & lat_now;
				default: fire = wrap;
			endcase
		end
		return fire;
	endfunction : reload_hit

	logic rl_fire_a;
	logic rl_fire_b;

	// each aux picks the transition it answers with its own trigger field
	assign rl_fire_a = reload_hit(tctl[IDX_AUX_A], ev_in[IDX_AUX_A],
		ovf[IDX_CORE1], latch1);
	assign rl_fire_b = reload_hit(tctl[IDX_AUX_B], ev_in[IDX_AUX_B],
		ovf[IDX_CORE1], latch1);

	// hardware loads between timers
	always_comb begin
		ld_en = '0;
		for (int k = 0; k < GPTU_NT; k++) begin
			ld_val[k] = 16'h0000;
		end
		for (int j = IDX_AUX_A; j <= IDX_AUX_B; j += 2) begin
			if (gptu_mode_t'(tctl[j][F_MODE +: 3]) == MODE_CAPTURE &&
				ev_in[j]) begin
				ld_en[j] = 1'b1;
				ld_val[j] = tval[IDX_CORE1];
			end
		end
		// value comes from the aux that fired
		if (rl_fire_a) begin
			ld_en[IDX_CORE1] = 1'b1;
			ld_val[IDX_CORE1] = tval[IDX_AUX_A];
		end

		// aux b is looked at last, so it wins a tie
		if (rl_fire_b) begin
			ld_en[IDX_CORE1] = 1'b1;
			ld_val[IDX_CORE1] = tval[IDX_AUX_B];
		end

		// wrap reloads core two from capture register
		if (tctl[IDX_CORE2][F_CORERLD] && ovf[IDX_CORE2]) begin
			ld_en[IDX_CORE2] = 1'b1;
			ld_val[IDX_CORE2] = capreg;
		end
		if (cap_fire && capctl[C_CLEAR]) begin
			ld_en[IDX_AUX2] = 1'b1;
			ld_val[IDX_AUX2] = 16'h0000;
		end
	end

	// toggle latches and their outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch1 <= 1'b0;
			latch1_d <= 1'b0;
			latch2 <= 1'b0;
			latch2_d <= 1'b0;
			outs <= '0;
		end else begin
			latch1 <= latch1 ^ ovf[IDX_CORE1];
			latch1_d <= latch1;
			latch2 <= latch2 ^ ovf[IDX_CORE2];
			latch2_d <= latch2;
			outs.core_one_toggle_out <= latch1 & tctl[IDX_CORE1][F_OUTEN];
			outs.core_two_toggle_out <= latch2 & tctl[IDX_CORE2][F_OUTEN];
			outs.core_two_ovf <= ovf[IDX_CORE2];
		end
	end

	// capture register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capreg <= VAL_RST;
		end else if (wr && paddr == OFF_CAPREG) begin
			capreg <= pwdata[15:0];
		end else if (cap_fire) begin
			capreg <= tval[IDX_AUX2];
		end
	end

	// apb: zero wait states, read data staged in setup phase
	assign wr = psel & penable & pwrite;
	assign acc = psel & penable;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;

	always_comb begin
		hit = 1'b0;
		next_rdata = 32'h00000000;
		for (int k = 0; k < GPTU_NT; k++) begin
			if (paddr == 12'(OFF_CTL + 4 * k)) begin
				hit = 1'b1;
				next_rdata = {16'h0000, tctl[k]};
			end
			if (paddr == 12'(OFF_VAL + 4 * k)) begin
				hit = 1'b1;
				next_rdata = {16'h0000, tval[k]};
			end
		end
		if (paddr == OFF_CAPCTL) begin
			hit = 1'b1;
			next_rdata = {27'h0000000, capctl};
		end
		if (paddr == OFF_STATUS) begin
			hit = 1'b1;
			next_rdata = {30'h00000000, latch2, latch1};
		end
		if (paddr == OFF_CAPREG) begin
			hit = 1'b1;
			next_rdata = {16'h0000, capreg};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < GPTU_NT; k++) begin
				tctl[k] <= CTL_RST;
			end
			capctl <= CAPCTL_RST;
		end else if (wr) begin
			for (int k = 0; k < GPTU_NT; k++) begin
				if (paddr == 12'(OFF_CTL + 4 * k)) begin
					tctl[k] <= pwdata[15:0];
				end
			end
			if (paddr == OFF_CAPCTL) begin
				capctl <= pwdata[CAPCTL_W-1:0];
			end
		end
	end
endmodule : gptu_top
`default_nettype wire

// [gptu_properties.sv]
// gptu_properties: port checks of the timer unit.
// assumes it is bound into gptu_top, one clock.
`timescale 1ns/1ps
`default_nettype none
module gptu_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire gptu_pkg::gptu_outs_t outs
);
	import gptu_pkg::*;
	logic mapped;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= OFF_CAPREG && paddr != 12'h014;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_quiet: assert property (!(psel && penable) |-> !pslverr)
		else $error("pslverr outside access");
	a_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (s_access ##0 mapped |-> !pslverr)
		else $error("mapped access refused");
	a_rd_stable: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved without setup");
	a_rd_refused: assert property (s_setup ##0 (!pwrite && !mapped) |=> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_rd_word16: assert property (prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	a_ovf_single: assert property (outs.core_two_ovf |=> !outs.core_two_ovf)
		else $error("wrap pulse longer than a cycle");
endmodule : gptu_properties
bind gptu_top gptu_properties i_gptu_properties (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .outs(outs));
`default_nettype wire

// [gptu_pin_src.sv]
// gptu_pin_src: external pulse, gate and sensor source for the pins.
// assumes its tasks are called right after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module gptu_pin_src (
	input wire logic pclk,
	output var gptu_pkg::gptu_pins_t pins
);
	import gptu_pkg::*;
	initial pins = '0;
	// each level held past one module-one slot
	task automatic level(input int b, input logic v);
		pins[b] <= v;
		repeat (8) @(posedge pclk);
	endtask : level
	task automatic pulse(input int b);
		level(b, 1'h1);
		level(b, 1'h0);
	endtask : pulse
endmodule : gptu_pin_src
`default_nettype wire

// [tb_top.sv]
// tb_top: register-level tests of the timer unit over APB.
// assumes zero-wait slave; pin bits: capture 0, updown 1+k, input 6+k.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gptu_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv, v0;
	logic pready, pslverr, er;
	logic ovf_seen = 1'h0;
	gptu_pins_t pins;
	gptu_outs_t outs;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	always #10 pclk = ~pclk;
	gptu_top i_gptu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.outs(outs));
	gptu_pin_src i_gptu_pin_src (.pclk(pclk), .pins(pins));
	task automatic summarize;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (outs.core_two_ovf === 1'h1) ovf_seen <= 1'h1;
		if (cyc == 8000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rv = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		xfer(1'h0, a, 32'h0);
	endtask : rd
	// steps counted over 40 cycles between two read setups
	task automatic rate(input int k, input logic [15:0] ctl, step);
		wr(OFF_VAL + 12'(4 * k), 32'h8000);
		wr(OFF_CTL + 12'(4 * k), {16'h0, ctl});
		rd(OFF_VAL + 12'(4 * k));
		v0 = rv;
		repeat (37) @(posedge pclk);
		rd(OFF_VAL + 12'(4 * k));
		chk("timer step", {16'h0, rv[15:0] - v0[15:0]}, {16'h0, step});
		wr(OFF_CTL + 12'(4 * k), 32'h0);
	endtask : rate
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		for (int k = 0; k < 5; k++) begin
			rd(OFF_CTL + 12'(4 * k));
			chk("ctl reset", rv, 32'h0);
			rd(OFF_VAL + 12'(4 * k));
			chk("value reset", rv, 32'h0);
		end
		rd(12'h014);
		chk("unmapped error", {31'h0, er}, 32'h1);
		chk("unmapped data", rv, 32'h0);
		for (int k = 0; k < 5; k++) begin
			rate(k, 16'h0040, k < 3 ? 16'h000A : 16'h0014);
			rate(k, 16'h00C0, k < 3 ? 16'hFFF6 : 16'hFFEC);
		end
		rate(1, 16'h0048, 16'h0005);
		rate(4, 16'h0048, 16'h000A);
		i_gptu_pin_src.level(2, 1'h1);
		rate(1, 16'h0140, 16'hFFF6);
		i_gptu_pin_src.level(2, 1'h0);
		rate(2, 16'h0042, 16'h0000);
		i_gptu_pin_src.level(8, 1'h1);
		rate(2, 16'h0042, 16'h000A);
		i_gptu_pin_src.level(8, 1'h0);
		wr(OFF_VAL + 12'h008, 32'h0100);
		wr(OFF_CTL + 12'h008, 32'h0646);
		i_gptu_pin_src.level(8, 1'h1);
		i_gptu_pin_src.level(3, 1'h1);
		i_gptu_pin_src.level(8, 1'h0);
		i_gptu_pin_src.level(3, 1'h0);
		rd(OFF_VAL + 12'h008);
		chk("quadrature", rv, 32'h0104);
		wr(OFF_CTL + 12'h008, 32'h0);
		wr(OFF_VAL, 32'h0);
		wr(OFF_CTL, 32'h0241);
		repeat (3) i_gptu_pin_src.pulse(6);
		rd(OFF_VAL);
		chk("event count", rv, 32'h3);
		wr(OFF_VAL + 12'h004, 32'h1234);
		wr(OFF_CTL, 32'h0245);
		i_gptu_pin_src.pulse(6);
		rd(OFF_VAL);
		chk("capture", rv, 32'h1234);
		wr(OFF_VAL + 12'h004, 32'hFFFE);
		wr(OFF_CTL + 12'h004, 32'h0840);
		repeat (20) @(posedge pclk);
		chk("toggle out", {31'h0, outs.core_one_toggle_out}, 32'h1);
		wr(OFF_CTL + 12'h004, 32'h0);
		wr(OFF_VAL, 32'h0100);
		wr(OFF_CTL, 32'h0204);
		i_gptu_pin_src.pulse(6);
		rd(OFF_VAL + 12'h004);
		chk("pin reload", rv, 32'h0100);
		wr(OFF_VAL, 32'h0010);
		wr(OFF_CTL, 32'h2004);
		wr(OFF_VAL + 12'h008, 32'hFFF0);
		wr(OFF_CTL + 12'h008, 32'h4004);
		wr(OFF_VAL + 12'h004, 32'hFFFE);
		wr(OFF_CTL + 12'h004, 32'h0040);
		repeat (100) @(posedge pclk);
		rd(OFF_VAL + 12'h004);
		chk("pwm phase", {24'h0, rv[15:8]}, 32'h0);
		wr(OFF_CTL + 12'h004, 32'h0);
		wr(OFF_VAL + 12'h00C, 32'h0042);
		wr(OFF_CAPCTL, 32'h11);
		i_gptu_pin_src.pulse(0);
		rd(OFF_CAPREG);
		chk("capture reg", rv, 32'h0042);
		rd(OFF_VAL + 12'h00C);
		chk("cleared aux", rv, 32'h0);
		wr(OFF_VAL + 12'h00C, 32'h0077);
		wr(OFF_CAPCTL, 32'h05);
		i_gptu_pin_src.pulse(7);
		rd(OFF_CAPREG);
		chk("pin capture", rv, 32'h0077);
		wr(OFF_VAL + 12'h010, 32'hFFFE);
		wr(OFF_CTL + 12'h010, 32'h0840);
		repeat (20) @(posedge pclk);
		chk("toggle out two", {31'h0, outs.core_two_toggle_out}, 32'h1);
		chk("wrap pulse", {31'h0, ovf_seen}, 32'h1);
		rd(OFF_STATUS);
		chk("latches", {30'h0, rv[1:0]}, 32'h3);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
